// [common/cid_pkg.sv]
// Package of constants for the CAN message identifier register block
package cid_pkg;
    // Byte offsets of the identifier registers inside one buffer
    localparam logic [1:0] OFF_IDENT_BYTE0 = 2'h0;
    localparam logic [1:0] OFF_IDENT_BYTE1 = 2'h1;
    localparam logic [1:0] OFF_IDENT_BYTE2 = 2'h2;
    localparam logic [1:0] OFF_IDENT_BYTE3 = 2'h3;
    // Field positions in ident_byte1
    localparam int B1_SRR_POS = 4;
    localparam int B1_IDE_POS = 3;
    // Field positions in ident_byte3
    localparam int B3_RTR_POS = 0;
    // Frame field widths
    localparam int EXT_ID_W = 29;
    localparam int STD_ID_W = 11;
    // Extended header: id[28:18], srr, ide, id[17:0], rtr = 32 bits
    localparam int EXT_HDR_W = 32;
    // Standard header: id[10:0], rtr, ide = 13 bits
    localparam int STD_HDR_W = 13;
    // Transmit header srr value, a fixed recessive bit
    localparam logic RECESSIVE = 1'b1;
endpackage : cid_pkg

// [logic/cid_id_pack.sv]
// Translates between identifier register bytes and frame header fields
`timescale 1ns/10ps
`default_nettype none
module cid_id_pack (
    input wire logic [7:0] byte0, // Identifier byte 0
    input wire logic [7:0] byte1, // Identifier byte 1
    input wire logic [7:0] byte2, // Identifier byte 2
    input wire logic [7:0] byte3, // Identifier byte 3
    output logic ide, // Extended format flag
    output logic rtr, // Remote frame flag
    output logic srr, // Substitute remote request
    output logic [28:0] ext_id, // Extended identifier
    output logic [10:0] std_id // Standard identifier
);
    // Extended layout field extraction
    assign ext_id = {byte0, byte1[7:5], byte1[2:0], byte2, byte3[7:1]};
    assign srr = byte1[cid_pkg::B1_SRR_POS];
    assign ide = byte1[cid_pkg::B1_IDE_POS];
    // Standard layout keeps rtr in byte1 bit 4, extended in byte3 bit 0
    assign std_id = {byte0, byte1[7:5]};
    assign rtr = ide ? byte3[cid_pkg::B3_RTR_POS] : byte1[cid_pkg::B1_SRR_POS];
endmodule : cid_id_pack
`default_nettype wire

// [logic/cid_ident_regs.sv]
// Identifier register group of one CAN message buffer with frame serialiser
// Function
// - Extended identifier held in 32 bits: 29 id, srr, ide, rtr.
// - Standard identifier held in 13 bits: 11 id, rtr, ide.
// - Byte0 holds id 28..21; byte1 holds id 20..18 high, 17..15 low.
// - Byte2 holds id 14..7; byte3 bits 7..1 hold id 6..0.
// - Id bit 28 is sent first, then lower bits descending.
// - Smallest identifier value wins priority.
// - Received srr stored exactly as seen on the bus.
// - Ide bit zero means standard, one means extended format.
// - Received ide loaded so software knows the layout.
// - Transmit sends standard or extended header by stored ide.
// - Received rtr loaded into byte3 bit 0 in extended layout.
// - Transmit sends stored rtr; clear is data, set is remote frame.
// - Identifier bytes have no defined reset value.
`timescale 1ns/10ps
`default_nettype none
module cid_ident_regs #(
    parameter bit IS_RX = 1'b0 // One for a receive buffer, zero for transmit
) (
    input wire logic clk, // 10 MHz clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic [1:0] addr, // Byte offset within identifier group
    input wire logic [7:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    output logic [7:0] rdata, // Read data, one cycle after rd
    input wire logic tx_buffer_empty_flag, // Transmit buffer free for software
    input wire logic tx_buffer_select, // Buffer chosen for software access
    input wire logic rx_full_flag, // Receive buffer holds a frame
    input wire logic hdr_start, // Start serialising header to bus
    input wire logic hdr_bit_en, // Bit-time enable pulse for serialiser
    output logic hdr_bit, // Header bit to bus, MSB first
    output logic hdr_busy, // Serialiser active
    output logic hdr_last, // Last header bit on hdr_bit
    input wire logic rx_load, // Store received header fields
    input wire logic rx_ide, // Received ide bit
    input wire logic rx_srr, // Received srr bit
    input wire logic rx_rtr, // Received rtr bit
    input wire logic [28:0] rx_id, // Received identifier, right aligned
    input wire logic [28:0] cmp_id, // Identifier of a competing buffer
    input wire logic cmp_ide, // Format of the competing identifier
    output logic wins_prio, // This buffer outranks the competitor
    output logic [28:0] id_out, // Identifier value, right aligned
    output logic ide_out, // Stored ide
    output logic rtr_out // Stored rtr
);
    typedef struct packed {
        logic [7:0] b0;
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] b3;
        logic [7:0] rdata;
        logic [31:0] sh;
        logic [5:0] cnt;
        logic busy;
    } cid_state_s;

    cid_state_s s_q;
    cid_state_s s_d;

    logic ide_w;
    logic rtr_w;
    logic srr_w;
    logic [28:0] ext_w;
    logic [10:0] std_w;
    logic sw_ok_wr;
    logic sw_ok_rd;
    logic [28:0] my_key;
    logic [28:0] cmp_key;

    // Decode the stored bytes into header fields
    cid_id_pack u_pack (
        .byte0(s_q.b0),
        .byte1(s_q.b1),
        .byte2(s_q.b2),
        .byte3(s_q.b3),
        .ide(ide_w),
        .rtr(rtr_w),
        .srr(srr_w),
        .ext_id(ext_w),
        .std_id(std_w)
    );

    // Access windows; software owns the buffer only in these states
    assign sw_ok_wr = !IS_RX && tx_buffer_empty_flag && tx_buffer_select;
    assign sw_ok_rd = IS_RX ? rx_full_flag : (tx_buffer_empty_flag && tx_buffer_select);

    // Priority keys: standard id is aligned to the extended id's top bits
    assign my_key = ide_w ? ext_w : {std_w, 18'h00000};
    assign cmp_key = cmp_ide ? cmp_id : {cmp_id[10:0], 18'h00000};
    assign wins_prio = (my_key < cmp_key);

    assign id_out = ide_w ? ext_w : {18'h00000, std_w};
    assign ide_out = ide_w;
    assign rtr_out = rtr_w;
    assign rdata = s_q.rdata;
    assign hdr_busy = s_q.busy;
    assign hdr_bit = s_q.sh[31];
    assign hdr_last = s_q.busy && (s_q.cnt == 6'h01);

    // Next state: register writes, receive loads and header shifting
    always_comb begin
        s_d = s_q;
        // Read data stand only in the cycle after the strobe
        s_d.rdata = 8'h00;
        if (rd && sw_ok_rd) begin
            unique case (addr)
                cid_pkg::OFF_IDENT_BYTE0: s_d.rdata = s_q.b0;
                cid_pkg::OFF_IDENT_BYTE1: s_d.rdata = s_q.b1;
                cid_pkg::OFF_IDENT_BYTE2: s_d.rdata = s_q.b2;
                cid_pkg::OFF_IDENT_BYTE3: s_d.rdata = s_q.b3;
            endcase
        end
        // Software writes; srr is kept as software writes it
        if (wr && sw_ok_wr) begin
            unique case (addr)
                cid_pkg::OFF_IDENT_BYTE0: s_d.b0 = wdata;
                cid_pkg::OFF_IDENT_BYTE1: s_d.b1 = wdata;
                cid_pkg::OFF_IDENT_BYTE2: s_d.b2 = wdata;
                cid_pkg::OFF_IDENT_BYTE3: s_d.b3 = wdata;
            endcase
        end
        // Receive load in whichever layout the frame used
        if (IS_RX && rx_load) begin
            if (rx_ide) begin
                s_d.b0 = rx_id[28:21];
                s_d.b1 = {rx_id[20:18], rx_srr, 1'b1, rx_id[17:15]};
                s_d.b2 = rx_id[14:7];
                s_d.b3 = {rx_id[6:0], rx_rtr};
            end else begin
                s_d.b0 = rx_id[10:3];
                s_d.b1 = {rx_id[2:0], rx_rtr, 1'b0, 3'h0};
            end
        end
        // Header serialiser: format chosen by stored ide
        if (!IS_RX && hdr_start && !s_q.busy) begin
            s_d.busy = 1'b1;
            if (ide_w) begin
                s_d.sh = {ext_w[28:18], cid_pkg::RECESSIVE, 1'b1, ext_w[17:0], rtr_w};
                s_d.cnt = 6'(cid_pkg::EXT_HDR_W);
            end else begin
                s_d.sh = {std_w, rtr_w, 1'b0, 19'h00000};
                s_d.cnt = 6'(cid_pkg::STD_HDR_W);
            end
        end else if (s_q.busy && hdr_bit_en) begin
            s_d.sh = {s_q.sh[30:0], 1'b0};
            s_d.cnt = s_q.cnt - 6'h01;
            if (s_q.cnt == 6'h01) begin
                s_d.busy = 1'b0;
            end
        end
    end

    // State register; identifier bytes are left untouched by reset
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q.rdata <= 8'h00;
            s_q.sh <= 32'h00000000;
            s_q.cnt <= 6'h00;
            s_q.busy <= 1'b0;
            s_q.b0 <= s_d.b0;
            s_q.b1 <= s_d.b1;
            s_q.b2 <= s_d.b2;
            s_q.b3 <= s_d.b3;
        end else begin
            s_q <= s_d;
        end
    end

    // Assertions guarding the block
    a_ext_first_bit: assert property (@(posedge clk) disable iff (rst)
        (!IS_RX && hdr_start && !s_q.busy && ide_w) |=> (hdr_bit == s_q.b0[7] && s_q.cnt == 6'h20))
        else $error("extended header does not start with id bit 28");
    a_std_len: assert property (@(posedge clk) disable iff (rst)
        (!IS_RX && hdr_start && !s_q.busy && !ide_w) |=> (s_q.cnt == 6'h0d))
        else $error("standard header length wrong");
    a_rtr_sent: assert property (@(posedge clk) disable iff (rst)
        (hdr_last && ide_w) |-> (hdr_bit == s_q.b3[0]))
        else $error("extended rtr not sent as stored");
    a_rx_srr_kept: assert property (@(posedge clk) disable iff (rst)
        (IS_RX && rx_load && rx_ide) |=> (s_q.b1[4] == $past(rx_srr) && s_q.b1[3]))
        else $error("received srr or ide not stored");
    a_rx_rtr_kept: assert property (@(posedge clk) disable iff (rst)
        (IS_RX && rx_load && rx_ide) |=> (s_q.b3[0] == $past(rx_rtr)))
        else $error("received rtr not stored");
    a_rx_std_ide: assert property (@(posedge clk) disable iff (rst)
        (IS_RX && rx_load && !rx_ide) |=> !s_q.b1[3])
        else $error("standard receive ide not cleared");
    a_ext_byte_map: assert property (@(posedge clk) disable iff (rst)
        (IS_RX && rx_load && rx_ide) |=> (ext_w == $past(rx_id)))
        else $error("extended byte layout mismatch");
    a_prio_order: assert property (@(posedge clk) disable iff (rst)
        (ide_w && cmp_ide && ext_w < cmp_id) |-> wins_prio)
        else $error("smaller identifier did not win");
    a_no_wr_locked: assert property (@(posedge clk) disable iff (rst)
        (wr && !sw_ok_wr && addr == 2'h0) |=> $stable(s_q.b0))
        else $error("write accepted outside access window");
    a_serial_done: assert property (@(posedge clk) disable iff (rst)
        (s_q.busy && hdr_bit_en && s_q.cnt == 6'h01) |=> !s_q.busy)
        else $error("serialiser did not stop after last bit");

    c_ext_tx: cover property (@(posedge clk) hdr_start && !s_q.busy && ide_w);
    c_std_tx: cover property (@(posedge clk) hdr_start && !s_q.busy && !ide_w);
    c_rx_load: cover property (@(posedge clk) rx_load && rx_ide);
    c_sw_read: cover property (@(posedge clk) rd && sw_ok_rd);
endmodule : cid_ident_regs
`default_nettype wire

// [testbench/can_msg_identifier_regs_test.sv]
// Self-checking bench for the identifier register group, transmit and receive
`timescale 1ns/10ps
`default_nettype none
module can_msg_identifier_regs_test;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, empty = 1'b0, sel = 1'b0, full = 1'b0, hdr_start = 1'b0;
    logic rx_load = 1'b0, rx_ide = 1'b0, rx_srr = 1'b0, rx_rtr = 1'b0, cmp_ide = 1'b1, en, hb, busy, wins, ide_t, rtr_t;
    logic [1:0] addr = 2'h0, gap = 2'h0;
    logic [7:0] wdata = 8'h0, rd_t, rd_r, dt, dr;
    logic [28:0] rx_id = 29'h0, cmp_id = 29'h0, id_t, id_r, id;
    logic [31:0] seed = 32'h2d, cap, v;
    logic [5:0] cnt;
    int err_count = 0, num_checks = 0, cyc = 0;
    always #50 clk = ~clk;
    cid_ident_regs #(.IS_RX(1'b0)) dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rd_t), .tx_buffer_empty_flag(empty), .tx_buffer_select(sel), .rx_full_flag(full),
        .hdr_start(hdr_start), .hdr_bit_en(en), .hdr_bit(hb), .hdr_busy(busy), .hdr_last(), .rx_load(rx_load),
        .rx_ide(rx_ide), .rx_srr(rx_srr), .rx_rtr(rx_rtr), .rx_id(rx_id), .cmp_id(cmp_id), .cmp_ide(cmp_ide),
        .wins_prio(wins), .id_out(id_t), .ide_out(ide_t), .rtr_out(rtr_t));
    cid_ident_regs #(.IS_RX(1'b1)) rx_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rd_r), .tx_buffer_empty_flag(empty), .tx_buffer_select(sel), .rx_full_flag(full),
        .hdr_start(hdr_start), .hdr_bit_en(en), .hdr_bit(), .hdr_busy(), .hdr_last(), .rx_load(rx_load),
        .rx_ide(rx_ide), .rx_srr(rx_srr), .rx_rtr(rx_rtr), .rx_id(rx_id), .cmp_id(cmp_id), .cmp_ide(cmp_ide),
        .wins_prio(), .id_out(id_r), .ide_out(), .rtr_out());
    cid_bus_node node_u (.clk(clk), .rst(rst), .clr(hdr_start), .gap(gap), .hdr_busy(busy), .hdr_bit(hb),
        .hdr_bit_en(en), .cap_q(cap), .cnt_q(cnt));
    // Fixed-seed shift register for repeatable random values
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    // Expected extended byte image, byte 0 highest
    function automatic logic [31:0] ext_img(input logic [28:0] i, input logic s, input logic r);
        return {i[28:18], s, 1'b1, i[17:0], r};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_b(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd_b(input logic [1:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        dt = rd_t;
        dr = rd_r;
    endtask
    task automatic send_hdr();
        int n;
        @(posedge clk);
        hdr_start <= 1'b1;
        @(posedge clk);
        hdr_start <= 1'b0;
        // Let the start edge settle so the loop sees the raised busy level
        #1;
        for (n = 0; n < 300 && busy !== 1'b0; n++) begin
            @(posedge clk);
            #1;
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Cuts a hang short well beyond the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            complete_run();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        empty <= 1'b1;
        sel <= 1'b1;
        // Fill the receive buffer once so its bytes are defined before refused writes
        rx_load <= 1'b1;
        rx_ide <= 1'b1;
        @(posedge clk);
        rx_load <= 1'b0;
        // Transmit buffer, extended layout, strobes with an idle cycle between them and random pacing
        for (int i = 0; i < 8; i++) begin
            v = rnd();
            id = v[28:0];
            gap <= v[30:29];
            cmp_id <= (i == 0) ? v[28:0] : rnd() >> 3;
            v = ext_img(id, 1'b1, v[31]);
            for (int k = 0; k < 4; k++) wr_b(k[1:0], v[31 - 8 * k -: 8]);
            for (int k = 0; k < 4; k++) begin
                rd_b(k[1:0]);
                check({24'h0, dt}, {24'h0, v[31 - 8 * k -: 8]});
            end
            check({id_t, ide_t, rtr_t, 1'b0}, {id, 1'b1, v[0], 1'b0});
            check({31'h0, wins}, {31'h0, id < cmp_id});
            send_hdr();
            check(cap, v);
            check({26'h0, cnt}, 32'h20);
            $display("extended transmit case %0d done", i);
        end
        // Standard layout with both frame kinds
        for (int r = 0; r < 2; r++) begin
            v = rnd();
            wr_b(2'h0, v[10:3]);
            wr_b(2'h1, {v[2:0], r[0], 1'b0, 3'h0});
            send_hdr();
            check(cap, {19'h0, v[10:0], r[0], 1'b0});
            check({26'h0, cnt}, 32'hd);
        end
        // Writes outside the access window are refused, reads give zero
        wr_b(2'h0, 8'h5a);
        empty <= 1'b0;
        wr_b(2'h0, 8'ha5);
        rd_b(2'h0);
        check({24'h0, dt}, 32'h0);
        empty <= 1'b1;
        rd_b(2'h0);
        check({24'h0, dt}, 32'h5a);
        $display("transmit window case done");
        // Receive buffer: stored fields follow the received frame exactly
        for (int i = 0; i < 6; i++) begin
            v = rnd();
            @(posedge clk);
            rx_load <= 1'b1;
            rx_id <= v[28:0];
            rx_srr <= v[29];
            rx_rtr <= v[30];
            rx_ide <= (i != 5);
            @(posedge clk);
            rx_load <= 1'b0;
            full <= 1'b0;
            rd_b(2'h1);
            check({24'h0, dr}, 32'h0);
            full <= 1'b1;
            wr_b(2'h1, ~v[20:13]);
            v = (i == 5) ? {v[10:3], v[2:0], v[30], 20'h0} : ext_img(v[28:0], v[29], v[30]);
            for (int k = 0; k < ((i == 5) ? 2 : 4); k++) begin
                rd_b(k[1:0]);
                check({24'h0, dr}, {24'h0, v[31 - 8 * k -: 8]});
            end
            $display("receive case %0d done", i);
        end
        complete_run();
    end
endmodule // can_msg_identifier_regs_test
`default_nettype wire

// [testbench/cid_bus_node.sv]
// Bus node model that paces header bit times and captures the bits sent
`timescale 1ns/10ps
`default_nettype none
module cid_bus_node (
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic clr, // Clears the capture at a frame start
    input wire logic [1:0] gap, // Idle cycles between bit times
    input wire logic hdr_busy, // Serialiser active
    input wire logic hdr_bit, // Header bit on the bus
    output logic hdr_bit_en, // Bit-time enable pulse
    output logic [31:0] cap_q, // Captured bits, first bit highest
    output logic [5:0] cnt_q // Number of bits captured
);
    logic [1:0] wait_q;
    // Pacing may be prompt or slow; bits are taken only while the sender is busy
    always_ff @(posedge clk) begin
        hdr_bit_en <= hdr_busy && (wait_q == gap);
        wait_q <= (!hdr_busy || wait_q == gap) ? 2'h0 : wait_q + 2'h1;
        if (rst || clr) begin
            cap_q <= 32'h0;
            cnt_q <= 6'h0;
        end else if (hdr_bit_en && hdr_busy) begin
            cap_q <= {cap_q[30:0], hdr_bit};
            cnt_q <= cnt_q + 6'h1;
        end
    end
endmodule // cid_bus_node
`default_nettype wire
